/* hdl/sfr_bank.sv */
// system, infrared, port and auxiliary ram register bank on ahb-lite
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - pll code selects main clock multiplier
// - sleep instruction: idle bit picks idle/sleep
// - booster clock: sub clock divided 1/4/8/16
// - cpu source bit stops or runs main osc
// - ir enable off: pin follows port 5
// - carrier off: width timers only, auto-reload
// - carrier on: low sections carry counter wave
// - low-only ignores high width timer
// - ir pin function drives port 5 bit 7
// - timer pin function takes port 5 bit 6
// - irq b pin function takes port 5 bit 5
// - irq a pin function takes port 5 bit 4
// - external irq flags set on their event
// - port 6/8 input change sets bit 7
// - timer underflows set flags 6 to 3
// - general timer overflow sets flag 0
// - direction 0 output, 1 high impedance
// - nibble selects hand pins to lcd segments
// - seven-bit aux ram address, msb zero
// - data register moves byte to aux ram
// - page 0 decoded while page bit is 0
// - page bit 1 hides control space: reads 0, writes dropped
module sfr_bank (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	input  wire logic                         sleep_instruction,
	output logic                              enter_sleep,
	output logic                              enter_idle,
	output logic                              main_osc_enable,
	output logic      [9:0]                   pll_mult_x4,
	input  wire logic                         sub_clock,
	output logic                              booster_clk,
	input  wire logic                         high_width_active,
	input  wire logic                         low_width_active,
	input  wire logic                         carrier_wave,
	output logic                              high_timer_enable,
	output logic                              counter_b_auto_reload,
	input  wire sfr_bank_pkg::timer_events_t  timer_events,
	output logic                              general_timer_pin,
	input  wire logic [3:0]                   p5_in,
	output logic      [3:0]                   p5_out,
	output logic      [3:0]                   p5_oe,
	input  wire logic [7:0]                   p6_in,
	input  wire logic [7:0]                   p7_in,
	input  wire logic [7:0]                   p8_in,
	input  wire logic [15:0]                  lcd_seg_hi,
	output sfr_bank_pkg::pin_drive_t          p6_drv,
	output sfr_bank_pkg::pin_drive_t          p7_drv,
	output sfr_bank_pkg::pin_drive_t          p8_drv
);
	// ******************************************************
	// state
	// ******************************************************
	// ports 5 and 6 come up as inputs, 7 and 8 as lcd segments; multiplier matches pll code zero
	localparam sfr_bank_pkg::bank_state_t STATE_RESET = '{
		bus:      sfr_bank_pkg::BUS_IDLE,
		pll_mult: sfr_bank_pkg::PLL_X130,
		p5_dir:   sfr_bank_pkg::DIR_RESET,
		p6_dir:   sfr_bank_pkg::DIR_RESET,
		p7_dir:   sfr_bank_pkg::DIR_RESET,
		p8_dir:   sfr_bank_pkg::DIR_RESET,
		default:  '0
	};

	sfr_bank_pkg::bank_state_t state_r;
	sfr_bank_pkg::bank_state_t state_nxt;

	// ******************************************************
	// helpers
	// ******************************************************
	// multiplier of the sub clock, times four to keep 65/4 whole
	function automatic logic [9:0] pll_mult(input logic [2:0] code);
		logic [9:0] m;
		m = sfr_bank_pkg::PLL_X244;
		unique case (code)
			3'h0: m = sfr_bank_pkg::PLL_X130;
			3'h1: m = sfr_bank_pkg::PLL_X65;
			3'h2: m = sfr_bank_pkg::PLL_X65_2;
			3'h3: m = sfr_bank_pkg::PLL_X65_4;
			default: m = sfr_bank_pkg::PLL_X244;
		endcase
		return m;
	endfunction

	// read value of a port: pin level on inputs, latch on outputs
	function automatic logic [7:0] port_read(input logic [7:0] data,
			input logic [7:0] dir, input logic [7:0] pin);
		return (dir & pin) | (~dir & data);
	endfunction

	// drive of an 8-bit port with optional lcd nibbles on top
	function automatic sfr_bank_pkg::pin_drive_t port_drive(
			input logic [7:0] data, input logic [7:0] dir,
			input logic seg_hi, input logic seg_lo,
			input logic [7:0] seg);
		sfr_bank_pkg::pin_drive_t d;
		d.out = data;
		d.oe = ~dir;
		if (seg_hi) begin
			d.out[7:4] = seg[7:4];
			d.oe[7:4] = 4'hf;
		end
		if (seg_lo) begin
			d.out[3:0] = seg[3:0];
			d.oe[3:0] = 4'hf;
		end
		return d;
	endfunction

	// ******************************************************
	// next state
	// ******************************************************
	always_comb begin
		logic       accept;
		logic       page0;
		logic       ctl_ok;
		logic       reg_ok;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [7:0] ev;
		logic       base;
		logic [7:0] p5_wide;
		logic [7:0] p5_pin;
		accept = 1'h0;
		page0 = 1'h0;
		ctl_ok = 1'h0;
		reg_ok = 1'h0;
		wd = 8'h00;
		rd = 8'h00;
		ev = 8'h00;
		base = 1'h0;
		p5_wide = 8'h00;
		p5_pin = 8'h00;
		state_nxt = state_r;

		// two-stage synchronisers, third stage only for edges
		state_nxt.p5_s1 = p5_in;
		state_nxt.p5_s2 = state_r.p5_s1;
		state_nxt.p5_s3 = state_r.p5_s2;
		state_nxt.p6_s1 = p6_in;
		state_nxt.p6_s2 = state_r.p6_s1;
		state_nxt.p6_s3 = state_r.p6_s2;
		state_nxt.p7_s1 = p7_in;
		state_nxt.p7_s2 = state_r.p7_s1;
		state_nxt.p8_s1 = p8_in;
		state_nxt.p8_s2 = state_r.p8_s1;
		state_nxt.p8_s3 = state_r.p8_s2;
		state_nxt.sub_s1 = sub_clock;
		state_nxt.sub_s2 = state_r.sub_s1;
		state_nxt.sub_s3 = state_r.sub_s2;

		// page bit decides whether the control space is page 0
		page0 = ~state_r.p5_data[sfr_bank_pkg::PAGE_BIT];
		ctl_ok = state_r.hit & state_r.ctl & page0;
		reg_ok = state_r.hit & ~state_r.ctl;
		wd = hwdata[7:0];

		// bus: writes land in their data phase, reads take a wait
		// state so a write just before is always visible
		accept = hsel & htrans[1] & hready;
		unique case (state_r.bus)
			sfr_bank_pkg::BUS_RD_WAIT:
				state_nxt.bus = sfr_bank_pkg::BUS_RD_DONE;
			default: begin
				if (accept) begin
					state_nxt.bus = hwrite ? sfr_bank_pkg::BUS_WRITE :
						sfr_bank_pkg::BUS_RD_WAIT;
				end else begin
					state_nxt.bus = sfr_bank_pkg::BUS_IDLE;
				end
			end
		endcase
		if (accept && state_r.bus != sfr_bank_pkg::BUS_RD_WAIT) begin
			state_nxt.hit = haddr[31:sfr_bank_pkg::HI_LSB] == '0;
			state_nxt.ctl = haddr[sfr_bank_pkg::SPACE_BIT];
			state_nxt.idx = haddr[sfr_bank_pkg::IDX_MSB:
				sfr_bank_pkg::IDX_LSB];
		end

		// register writes; unmapped or page 1 writes are dropped
		if (state_r.bus == sfr_bank_pkg::BUS_WRITE) begin
			if (reg_ok) begin
				unique case (state_r.idx)
					sfr_bank_pkg::IDX_PORT5:
						state_nxt.p5_data = wd & sfr_bank_pkg::MASK_P5;
					sfr_bank_pkg::IDX_PORT6: state_nxt.p6_data = wd;
					sfr_bank_pkg::IDX_PORT7: state_nxt.p7_data = wd;
					sfr_bank_pkg::IDX_PORT8: state_nxt.p8_data = wd;
					sfr_bank_pkg::IDX_SYS_CLK:
						state_nxt.sys_ctl = wd & sfr_bank_pkg::MASK_SYS;
					sfr_bank_pkg::IDX_IR_CTL:
						state_nxt.ir_ctl = wd & sfr_bank_pkg::MASK_IR;
					sfr_bank_pkg::IDX_FLAGS: state_nxt.flags = wd;
					default: ;
				endcase
			end
			if (ctl_ok) begin
				unique case (state_r.idx)
					sfr_bank_pkg::IDX_PORT5: state_nxt.p5_dir = wd;
					sfr_bank_pkg::IDX_PORT6: state_nxt.p6_dir = wd;
					sfr_bank_pkg::IDX_PORT7: state_nxt.p7_dir = wd;
					sfr_bank_pkg::IDX_PORT8: state_nxt.p8_dir = wd;
					sfr_bank_pkg::IDX_RAM_ADDR:
						state_nxt.ram_addr = wd &
							sfr_bank_pkg::MASK_RAM_ADDR;
					sfr_bank_pkg::IDX_RAM_DATA:
						state_nxt.ram[state_r.ram_addr[6:0]] = wd;
					default: ;
				endcase
			end
		end

		// read mux, sampled at the end of the wait state
		p5_wide = {state_r.p5_s2, 4'h0};
		p5_pin = port_read(state_r.p5_data, state_r.p5_dir, p5_wide);
		if (reg_ok) begin
			unique case (state_r.idx)
				sfr_bank_pkg::IDX_PORT5:
					rd = p5_pin & sfr_bank_pkg::MASK_P5;
				sfr_bank_pkg::IDX_PORT6: rd = port_read(state_r.p6_data,
					state_r.p6_dir, state_r.p6_s2);
				sfr_bank_pkg::IDX_PORT7: rd = port_read(state_r.p7_data,
					state_r.p7_dir, state_r.p7_s2);
				sfr_bank_pkg::IDX_PORT8: rd = port_read(state_r.p8_data,
					state_r.p8_dir, state_r.p8_s2);
				sfr_bank_pkg::IDX_SYS_CLK: rd = state_r.sys_ctl;
				sfr_bank_pkg::IDX_IR_CTL: rd = state_r.ir_ctl;
				sfr_bank_pkg::IDX_FLAGS: rd = state_r.flags;
				default: rd = 8'h00;
			endcase
		end else if (ctl_ok) begin
			unique case (state_r.idx)
				sfr_bank_pkg::IDX_PORT5: rd = state_r.p5_dir;
				sfr_bank_pkg::IDX_PORT6: rd = state_r.p6_dir;
				sfr_bank_pkg::IDX_PORT7: rd = state_r.p7_dir;
				sfr_bank_pkg::IDX_PORT8: rd = state_r.p8_dir;
				sfr_bank_pkg::IDX_RAM_ADDR: rd = state_r.ram_addr;
				sfr_bank_pkg::IDX_RAM_DATA:
					rd = state_r.ram[state_r.ram_addr[6:0]];
				default: rd = 8'h00;
			endcase
		end
		if (state_r.bus == sfr_bank_pkg::BUS_RD_WAIT) begin
			state_nxt.rdata = {24'h000000, rd};
		end

		// events set flags after the write, so a set beats a clear
		ev[sfr_bank_pkg::F_PIN_CHG] = |(((state_r.p6_s2 ^ state_r.p6_s3)
			& state_r.p6_dir) | ((state_r.p8_s2 ^ state_r.p8_s3)
			& state_r.p8_dir));
		ev[sfr_bank_pkg::F_LOW_W] = timer_events.low_width_underflow;
		ev[sfr_bank_pkg::F_HIGH_W] = timer_events.high_width_underflow;
		ev[sfr_bank_pkg::F_CNT_B] = timer_events.counter_b_underflow;
		ev[sfr_bank_pkg::F_CNT_A] = timer_events.counter_a_underflow;
		ev[sfr_bank_pkg::F_TMR] = timer_events.general_timer_overflow;
		// rising edges of the irq pins while their function is on
		ev[sfr_bank_pkg::F_IRQ_B] = state_r.ir_ctl[
			sfr_bank_pkg::IRQ_B_PIN_BIT] & state_r.p5_s2[1] &
			~state_r.p5_s3[1];
		ev[sfr_bank_pkg::F_IRQ_A] = state_r.ir_ctl[
			sfr_bank_pkg::IRQ_A_PIN_BIT] & state_r.p5_s2[0] &
			~state_r.p5_s3[0];
		state_nxt.flags = state_nxt.flags | ev;

		// clock controls
		state_nxt.pll_mult = pll_mult(state_r.sys_ctl[
			sfr_bank_pkg::PLL_MSB:sfr_bank_pkg::PLL_LSB]);
		state_nxt.sleep_p = sleep_instruction &
			~state_r.sys_ctl[sfr_bank_pkg::IDLE_BIT];
		state_nxt.idle_p = sleep_instruction &
			state_r.sys_ctl[sfr_bank_pkg::IDLE_BIT];
		// the divider counts synchronised sub clock rising edges
		if (state_r.sub_s2 && !state_r.sub_s3) begin
			state_nxt.boost_cnt = state_r.boost_cnt + 4'h1;
		end
		unique case (state_r.sys_ctl[sfr_bank_pkg::BOOST_LSB +: 2])
			2'h0: state_nxt.boost_clk = state_r.sub_s2;
			2'h1: state_nxt.boost_clk = state_r.boost_cnt[1];
			2'h2: state_nxt.boost_clk = state_r.boost_cnt[2];
			2'h3: state_nxt.boost_clk = state_r.boost_cnt[3];
		endcase

		// infrared waveform from the width timers and the carrier
		base = state_r.ir_ctl[sfr_bank_pkg::LOW_ONLY_BIT] ?
			~low_width_active : high_width_active;
		state_nxt.ir_wave = state_r.ir_ctl[sfr_bank_pkg::IRE_BIT] &
			(base | (state_r.ir_ctl[sfr_bank_pkg::CARRIER_BIT] &
			~base & carrier_wave));

		// port 5 pins; alternate inputs release the pin driver
		state_nxt.p5_out = state_r.p5_data[7:4];
		state_nxt.p5_oe = ~state_r.p5_dir[7:4];
		if (state_r.ir_ctl[sfr_bank_pkg::IR_PIN_BIT] &&
				state_r.ir_ctl[sfr_bank_pkg::IRE_BIT]) begin
			state_nxt.p5_out[3] = state_r.ir_wave;
			state_nxt.p5_oe[3] = 1'h1;
		end
		if (state_r.ir_ctl[sfr_bank_pkg::TMR_PIN_BIT]) begin
			state_nxt.p5_oe[2] = 1'h0;
		end
		if (state_r.ir_ctl[sfr_bank_pkg::IRQ_B_PIN_BIT]) begin
			state_nxt.p5_oe[1] = 1'h0;
		end
		if (state_r.ir_ctl[sfr_bank_pkg::IRQ_A_PIN_BIT]) begin
			state_nxt.p5_oe[0] = 1'h0;
		end
		state_nxt.tmr_pin = state_r.ir_ctl[sfr_bank_pkg::TMR_PIN_BIT] &
			state_r.p5_s2[2];

		// ports 6 to 8, with lcd segments borrowing 7 and 8
		state_nxt.p6_drv = port_drive(state_r.p6_data, state_r.p6_dir,
			1'h0, 1'h0, 8'h00);
		state_nxt.p7_drv = port_drive(state_r.p7_data, state_r.p7_dir,
			state_r.p5_dir[sfr_bank_pkg::P7_HI_SEG],
			state_r.p5_dir[sfr_bank_pkg::P7_LO_SEG],
			lcd_seg_hi[7:0]);
		state_nxt.p8_drv = port_drive(state_r.p8_data, state_r.p8_dir,
			state_r.p5_dir[sfr_bank_pkg::P8_HI_SEG],
			state_r.p5_dir[sfr_bank_pkg::P8_LO_SEG],
			lcd_seg_hi[15:8]);
	end

	// ******************************************************
	// registers
	// ******************************************************
	// one register stage for the whole bank
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= STATE_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ******************************************************
	// outputs
	// ******************************************************
	// the ready handshake, high timer enable and counter b auto reload are combinational
	assign hreadyout = state_r.bus != sfr_bank_pkg::BUS_RD_WAIT;
	assign hresp = 1'h0;
	assign hrdata = state_r.rdata;
	assign enter_sleep = state_r.sleep_p;
	assign enter_idle = state_r.idle_p;
	// main osc stopped while the cpu runs from the sub clock
	assign main_osc_enable = state_r.sys_ctl[sfr_bank_pkg::CPU_OSC_BIT];
	assign pll_mult_x4 = state_r.pll_mult;
	assign booster_clk = state_r.boost_clk;
	// low-only leaves the high timer idle; no carrier frees counter b
	assign high_timer_enable = state_r.ir_ctl[sfr_bank_pkg::IRE_BIT] &
		~state_r.ir_ctl[sfr_bank_pkg::LOW_ONLY_BIT];
	assign counter_b_auto_reload =
		~state_r.ir_ctl[sfr_bank_pkg::CARRIER_BIT];
	assign general_timer_pin = state_r.tmr_pin;
	assign p5_out = state_r.p5_out;
	assign p5_oe = state_r.p5_oe;
	assign p6_drv = state_r.p6_drv;
	assign p7_drv = state_r.p7_drv;
	assign p8_drv = state_r.p8_drv;
endmodule

/* pkg/sfr_bank_pkg.sv */
// register map, field layout and pin carriers of the system register bank
package sfr_bank_pkg;
	// word index of each register; byte address is four times the index
	localparam logic [3:0] IDX_PORT5 = 4'h5;
	localparam logic [3:0] IDX_PORT6 = 4'h6;
	localparam logic [3:0] IDX_PORT7 = 4'h7;
	localparam logic [3:0] IDX_PORT8 = 4'h8;
	localparam logic [3:0] IDX_RAM_ADDR = 4'h9;
	localparam logic [3:0] IDX_RAM_DATA = 4'ha;
	localparam logic [3:0] IDX_SYS_CLK = 4'hd;
	localparam logic [3:0] IDX_IR_CTL = 4'he;
	localparam logic [3:0] IDX_FLAGS = 4'hf;
	// haddr layout: [6] picks the paged control space, [5:2] the index
	localparam int SPACE_BIT = 6;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 5;
	localparam int HI_LSB = 7;
	// port 5 data register and port 5 direction/segment register
	localparam int PAGE_BIT = 0;
	localparam int P5_LSB = 4;
	localparam int P8_HI_SEG = 3;
	localparam int P8_LO_SEG = 2;
	localparam int P7_HI_SEG = 1;
	localparam int P7_LO_SEG = 0;
	// system clock control fields
	localparam int CPU_OSC_BIT = 0;
	localparam int BOOST_LSB = 1;
	localparam int IDLE_BIT = 3;
	localparam int PLL_LSB = 4;
	localparam int PLL_MSB = 6;
	// infrared and pin function fields
	localparam int IRE_BIT = 7;
	localparam int CARRIER_BIT = 6;
	localparam int LOW_ONLY_BIT = 5;
	localparam int IR_PIN_BIT = 3;
	localparam int TMR_PIN_BIT = 2;
	localparam int IRQ_B_PIN_BIT = 1;
	localparam int IRQ_A_PIN_BIT = 0;
	// interrupt flag positions
	localparam int F_PIN_CHG = 7;
	localparam int F_LOW_W = 6;
	localparam int F_HIGH_W = 5;
	localparam int F_CNT_B = 4;
	localparam int F_CNT_A = 3;
	localparam int F_IRQ_B = 2;
	localparam int F_IRQ_A = 1;
	localparam int F_TMR = 0;
	// readable bits of each register; the rest reads zero
	localparam logic [7:0] MASK_P5 = 8'hf1;
	localparam logic [7:0] MASK_SYS = 8'h7f;
	localparam logic [7:0] MASK_IR = 8'hef;
	localparam logic [7:0] MASK_RAM_ADDR = 8'h7f;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] REG_RESET = 8'h00;
	// main clock as sub clock multiple, scaled by four
	localparam logic [9:0] PLL_X130 = 10'h208;
	localparam logic [9:0] PLL_X65 = 10'h104;
	localparam logic [9:0] PLL_X65_2 = 10'h082;
	localparam logic [9:0] PLL_X65_4 = 10'h041;
	localparam logic [9:0] PLL_X244 = 10'h3d0;
	typedef enum logic [1:0] {
		BUS_IDLE    = 2'b00,
		BUS_WRITE   = 2'b01,
		BUS_RD_WAIT = 2'b10,
		BUS_RD_DONE = 2'b11
	} bus_state_t;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_t;
	typedef struct packed {
		logic low_width_underflow;
		logic high_width_underflow;
		logic counter_b_underflow;
		logic counter_a_underflow;
		logic general_timer_overflow;
	} timer_events_t;
	// whole state of the bank, registered in one stage
	typedef struct packed {
		bus_state_t       bus;
		logic             hit;
		logic             ctl;
		logic [3:0]       idx;
		logic [31:0]      rdata;
		logic [7:0]       p5_data;
		logic [7:0]       p6_data;
		logic [7:0]       p7_data;
		logic [7:0]       p8_data;
		logic [7:0]       p5_dir;
		logic [7:0]       p6_dir;
		logic [7:0]       p7_dir;
		logic [7:0]       p8_dir;
		logic [7:0]       ram_addr;
		logic [7:0]       sys_ctl;
		logic [7:0]       ir_ctl;
		logic [7:0]       flags;
		logic [127:0][7:0] ram;
		logic [3:0]       p5_s1;
		logic [3:0]       p5_s2;
		logic [3:0]       p5_s3;
		logic [7:0]       p6_s1;
		logic [7:0]       p6_s2;
		logic [7:0]       p6_s3;
		logic [7:0]       p7_s1;
		logic [7:0]       p7_s2;
		logic [7:0]       p8_s1;
		logic [7:0]       p8_s2;
		logic [7:0]       p8_s3;
		logic             sub_s1;
		logic             sub_s2;
		logic             sub_s3;
		logic [3:0]       boost_cnt;
		logic             boost_clk;
		logic             ir_wave;
		logic             sleep_p;
		logic             idle_p;
		logic [9:0]       pll_mult;
		logic             tmr_pin;
		logic [3:0]       p5_out;
		logic [3:0]       p5_oe;
		pin_drive_t       p6_drv;
		pin_drive_t       p7_drv;
		pin_drive_t       p8_drv;
	} bank_state_t;
endpackage

/* verification/sfr_bank_assertions.sv */
// concurrent checks on the ports of the system register bank
`timescale 1ns/1ps
module sfr_bank_checker (
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic        sleep_instruction,
	input logic        enter_sleep,
	input logic        enter_idle,
	input logic        main_osc_enable,
	input logic [9:0]  pll_mult_x4,
	input logic        high_timer_enable,
	input logic        counter_b_auto_reload
);
	// ********************************
	// write data phase tracker
	// ********************************
	logic wphase_r;

	// register outputs may only move after a write has been taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wphase_r <= 1'b0;
		end else if (hready) begin
			wphase_r <= hsel && htrans[1] && hwrite;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_sleep_one_mode: assert property (sleep_instruction |=>
		enter_sleep != enter_idle) else $error("sleep gave no single mode");
	a_sleep_quiet: assert property (!sleep_instruction |=>
		!enter_sleep && !enter_idle) else $error("mode pulse without cause");
	a_read_one_wait: assert property (hsel && htrans[1] && !hwrite
		&& hready |=> !hreadyout ##1 hreadyout) else $error("read wait");
	a_write_no_wait: assert property (wphase_r |-> hreadyout)
		else $error("write data phase stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_pll_legal: assert property (pll_mult_x4 inside {10'h208,
		10'h104, 10'h082, 10'h041, 10'h3d0}) else $error("bad multiplier");
	a_pll_cause: assert property ($changed(pll_mult_x4) |->
		$past(wphase_r) || $past(wphase_r, 2)) else $error("pll moved");
	a_osc_cause: assert property ($changed(main_osc_enable) |->
		$past(wphase_r)) else $error("oscillator select moved");
	a_htimer_cause: assert property ($changed(high_timer_enable) |->
		$past(wphase_r)) else $error("high timer enable moved");
	a_reload_cause: assert property ($changed(counter_b_auto_reload)
		|-> $past(wphase_r)) else $error("auto reload moved");
endmodule

bind sfr_bank sfr_bank_checker i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp),
	.sleep_instruction(sleep_instruction), .enter_sleep(enter_sleep),
	.enter_idle(enter_idle), .main_osc_enable(main_osc_enable),
	.pll_mult_x4(pll_mult_x4), .high_timer_enable(high_timer_enable),
	.counter_b_auto_reload(counter_b_auto_reload)
);

/* verification/test_sfr_bank.sv */
// self-checking bench for the system register bank
`timescale 1ns/1ps
module test_sfr_bank;
	logic                       hclk = 1'b0;
	logic                       hresetn = 1'b0;
	logic                       hsel = 1'b0;
	logic [31:0]                haddr = 32'h0;
	logic [1:0]                 htrans = 2'h0;
	logic                       hwrite = 1'b0;
	logic [31:0]                hwdata = 32'h0;
	logic [31:0]                hrdata;
	logic                       hreadyout, hresp, enter_sleep, enter_idle;
	logic                       main_osc_enable, booster_clk;
	logic                       high_timer_enable, counter_b_auto_reload;
	logic                       general_timer_pin;
	logic [9:0]                 pll_mult_x4;
	logic [3:0]                 p5_out, p5_oe;
	logic                       sleep_instruction = 1'b0;
	logic                       sub_clock = 1'b0;
	logic                       high_width_active = 1'b0;
	logic                       low_width_active = 1'b0;
	logic                       carrier_wave = 1'b0;
	logic [3:0]                 p5_in = 4'h0;
	logic [7:0]                 p6_in = 8'h0;
	logic [15:0]                lcd_seg_hi = 16'h0;
	sfr_bank_pkg::timer_events_t timer_events = '0;
	sfr_bank_pkg::pin_drive_t   p6_drv, p7_drv, p8_drv;
	int                         miscompares = 0;
	int                         cmp_count = 0;
	logic [31:0]                q;
	realtime                    t;
	// ir control, then high, low, carrier inputs, then pin, timer, reload
	logic [13:0] ir_tab [7] = '{{8'h88, 6'b100111}, {8'h88, 6'b000011},
		{8'ha8, 6'b110001}, {8'ha8, 6'b100101}, {8'hc8, 6'b001110},
		{8'hc8, 6'b000010}, {8'h08, 6'b100001}};

	sfr_bank i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sleep_instruction(sleep_instruction),
		.enter_sleep(enter_sleep), .enter_idle(enter_idle),
		.main_osc_enable(main_osc_enable), .pll_mult_x4(pll_mult_x4),
		.sub_clock(sub_clock), .booster_clk(booster_clk),
		.high_width_active(high_width_active),
		.low_width_active(low_width_active), .carrier_wave(carrier_wave),
		.high_timer_enable(high_timer_enable),
		.counter_b_auto_reload(counter_b_auto_reload),
		.timer_events(timer_events), .general_timer_pin(general_timer_pin),
		.p5_in(p5_in), .p5_out(p5_out), .p5_oe(p5_oe), .p6_in(p6_in),
		.p7_in(8'h0), .p8_in(8'h0), .lcd_seg_hi(lcd_seg_hi),
		.p6_drv(p6_drv), .p7_drv(p7_drv), .p8_drv(p8_drv)
	);

	// ********************************
	// clocks and bus tasks
	// ********************************
	always #2.5 hclk = ~hclk;

	// slow sub clock keeps the booster divider busy
	always begin
		repeat (40) @(posedge hclk);
		sub_clock <= ~sub_clock;
	end

	// byte address of a register index, ctl picks the paged space
	function automatic logic [31:0] ra(input logic [3:0] idx,
		input logic ctl);
		return {25'h0, ctl, idx, 2'h0};
	endfunction

	// one single transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// a hang counts as a mismatch; the tests need well under this span
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		conclude();
	end

	// ********************************
	// test sequence
	// ********************************
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		hsel <= 1'b1;
		rd_chk(ra(sfr_bank_pkg::IDX_PORT6, 1'b1), 32'hff);
		wr(ra(sfr_bank_pkg::IDX_SYS_CLK, 1'b0), 32'hff);
		rd_chk(ra(sfr_bank_pkg::IDX_SYS_CLK, 1'b0), 32'h7f);
		wr(ra(sfr_bank_pkg::IDX_IR_CTL, 1'b0), 32'hff);
		rd_chk(ra(sfr_bank_pkg::IDX_IR_CTL, 1'b0), 32'hef);
		rd_chk(ra(4'hb, 1'b0), 32'h0);
		// every multiplier code, cpu on main oscillator
		for (int c = 0; c < 8; c++) begin
			wr(ra(sfr_bank_pkg::IDX_SYS_CLK, 1'b0), {25'h0, c[2:0], 4'h1});
			repeat (2) @(posedge hclk);
			chk(pll_mult_x4, c[2] ? 10'h3d0 : 10'h208 >> c[1:0]);
			chk(main_osc_enable, 1'b1);
		end
		// one-cycle sleep request, core follows it with a no-op
		for (int m = 0; m < 2; m++) begin
			wr(ra(sfr_bank_pkg::IDX_SYS_CLK, 1'b0), {28'h0, m[0], 3'h0});
			sleep_instruction <= 1'b1;
			@(posedge hclk);
			sleep_instruction <= 1'b0;
			@(posedge hclk);
			chk({enter_idle, enter_sleep}, {m[0], ~m[0]});
		end
		// booster period per code; the edge cut by the switch is skipped
		for (int b = 0; b < 4; b++) begin
			wr(ra(sfr_bank_pkg::IDX_SYS_CLK, 1'b0), {29'h0, b[1:0], 1'h0});
			repeat (2) @(posedge booster_clk);
			t = $realtime;
			@(posedge booster_clk);
			chk(int'($realtime - t), b == 0 ? 400 : 400 << (b + 1));
		end
		chk(main_osc_enable, 1'b0);
		// pin 7 as driven output, then the waveform table
		wr(ra(sfr_bank_pkg::IDX_PORT5, 1'b1), 32'h70);
		foreach (ir_tab[i]) begin
			wr(ra(sfr_bank_pkg::IDX_IR_CTL, 1'b0), {24'h0, ir_tab[i][13:6]});
			high_width_active <= ir_tab[i][5];
			low_width_active <= ir_tab[i][4];
			carrier_wave <= ir_tab[i][3];
			repeat (4) @(posedge hclk);
			chk({p5_oe[3], p5_out[3], high_timer_enable,
				counter_b_auto_reload}, {1'b1, ir_tab[i][2:0]});
		end
		// pin functions on pins 6..4 and their flags
		wr(ra(sfr_bank_pkg::IDX_IR_CTL, 1'b0), 32'h07);
		wr(ra(sfr_bank_pkg::IDX_FLAGS, 1'b0), 32'h0);
		p5_in <= 4'h6;
		repeat (6) @(posedge hclk);
		chk(general_timer_pin, 1'b1);
		chk(p5_oe[2:0], 3'h0);
		rd_chk(ra(sfr_bank_pkg::IDX_FLAGS, 1'b0), 32'h04);
		timer_events <= 5'h1f;
		@(posedge hclk);
		timer_events <= 5'h0;
		rd_chk(ra(sfr_bank_pkg::IDX_FLAGS, 1'b0), 32'h7d);
		wr(ra(sfr_bank_pkg::IDX_FLAGS, 1'b0), 32'h0);
		p6_in <= 8'h08;
		p5_in <= 4'h7;
		repeat (6) @(posedge hclk);
		rd_chk(ra(sfr_bank_pkg::IDX_FLAGS, 1'b0), 32'h82);
		// direction and data on port 6
		wr(ra(sfr_bank_pkg::IDX_PORT6, 1'b1), 32'h0f);
		wr(ra(sfr_bank_pkg::IDX_PORT6, 1'b0), 32'ha5);
		repeat (3) @(posedge hclk);
		chk({p6_drv.oe, p6_drv.out[7:4]}, 12'hf0a);
		// port 7 low and port 8 high nibbles handed to segments
		wr(ra(sfr_bank_pkg::IDX_PORT5, 1'b1), 32'h79);
		lcd_seg_hi <= 16'h500a;
		repeat (3) @(posedge hclk);
		chk({p7_drv.oe, p7_drv.out[3:0]}, 12'h0fa);
		chk({p8_drv.oe, p8_drv.out[7:4]}, 12'hf05);
		// auxiliary ram window
		wr(ra(sfr_bank_pkg::IDX_RAM_ADDR, 1'b1), 32'hff);
		rd_chk(ra(sfr_bank_pkg::IDX_RAM_ADDR, 1'b1), 32'h7f);
		wr(ra(sfr_bank_pkg::IDX_RAM_DATA, 1'b1), 32'h5a);
		wr(ra(sfr_bank_pkg::IDX_RAM_ADDR, 1'b1), 32'h12);
		wr(ra(sfr_bank_pkg::IDX_RAM_DATA, 1'b1), 32'ha5);
		wr(ra(sfr_bank_pkg::IDX_RAM_ADDR, 1'b1), 32'h7f);
		rd_chk(ra(sfr_bank_pkg::IDX_RAM_DATA, 1'b1), 32'h5a);
		wr(ra(sfr_bank_pkg::IDX_RAM_ADDR, 1'b1), 32'h12);
		rd_chk(ra(sfr_bank_pkg::IDX_RAM_DATA, 1'b1), 32'ha5);
		// page bit set hides page 0, writes there are dropped
		wr(ra(sfr_bank_pkg::IDX_PORT5, 1'b0), 32'h01);
		rd_chk(ra(sfr_bank_pkg::IDX_PORT6, 1'b1), 32'h0);
		wr(ra(sfr_bank_pkg::IDX_PORT6, 1'b1), 32'h00);
		wr(ra(sfr_bank_pkg::IDX_PORT5, 1'b0), 32'h00);
		rd_chk(ra(sfr_bank_pkg::IDX_PORT6, 1'b1), 32'h0f);
		conclude();
	end
endmodule
